// *** verilog/mtr_pkg.sv ***
// constants of the threshold, no-load and rms register bank
package mtr_pkg;
    // register word indices; byte address is four times the index
    localparam logic [15:0] IDX_APPARENT_THR_HIGH = 16'h43A9;
    localparam logic [15:0] IDX_APPARENT_THR_LOW = 16'h43AA;
    localparam logic [15:0] IDX_ACTIVE_THR_HIGH = 16'h43AB;
    localparam logic [15:0] IDX_ACTIVE_THR_LOW = 16'h43AC;
    localparam logic [15:0] IDX_REACTIVE_THR_HIGH = 16'h43AD;
    localparam logic [15:0] IDX_REACTIVE_THR_LOW = 16'h43AE;
    localparam logic [15:0] IDX_RESERVED_KEEP_ZERO_A = 16'h43AF;
    localparam logic [15:0] IDX_APPARENT_NOLOAD = 16'h43B0;
    localparam logic [15:0] IDX_ACTIVE_NOLOAD = 16'h43B1;
    localparam logic [15:0] IDX_REACTIVE_NOLOAD = 16'h43B2;
    localparam logic [15:0] IDX_FUNDAMENTAL_LEVEL = 16'h43B3;
    localparam logic [15:0] IDX_RESERVED_NO_WRITE_B = 16'h43B4;
    localparam logic [15:0] IDX_INTEGRATOR_COEFF = 16'h43B5;
    localparam logic [15:0] IDX_HIGHPASS_DISABLE = 16'h43B6;
    localparam logic [15:0] IDX_RESERVED_KEEP_ZERO_C = 16'h43B7;
    localparam logic [15:0] IDX_NEUTRAL_MISMATCH = 16'h43B8;
    localparam logic [15:0] IDX_PHASE_CURRENT_TOTAL = 16'h43BF;
    localparam logic [15:0] IDX_PHASE_A_CURRENT_RMS = 16'h43C0;
    localparam logic [15:0] IDX_PHASE_A_VOLTAGE_RMS = 16'h43C1;
    localparam logic [15:0] IDX_PHASE_B_CURRENT_RMS = 16'h43C2;
    localparam logic [15:0] IDX_PHASE_B_VOLTAGE_RMS = 16'h43C3;
    localparam logic [15:0] IDX_PHASE_C_CURRENT_RMS = 16'h43C4;
    localparam logic [15:0] IDX_PHASE_C_VOLTAGE_RMS = 16'h43C5;
    localparam logic [15:0] IDX_NEUTRAL_CURRENT_RMS = 16'h43C6;
    localparam logic [15:0] IDX_WINDOW_LAST = 16'h43FF;
    // configuration words occupy indices 0x43A9..0x43B8
    localparam int CFG_WORDS = 16;
    localparam logic [15:0] CFG_WRITABLE = 16'hB7BF;
    localparam logic [15:0] CFG_SIGNED = 16'h9780;
    localparam logic [23:0] CFG_RESET = 24'h000000;
    // field widths
    localparam int REG_W = 24;
    localparam int TOTAL_W = 28;
    // coefficient the host loads while the integrator runs
    localparam logic [23:0] INTEGRATOR_COEFF_ON = 24'hFF8000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** verilog/mtr_regs.sv ***
// threshold, no-load, rms register bank behind an axi4-lite slave
// Function
// - apparent threshold is 48 bits, high half at 0x43A9, low half at 0x43AA
// - active threshold is 48 bits, high half at 0x43AB, low at 0x43AC
// - reactive threshold is 48 bits, high half at 0x43AD, low at 0x43AE
// - signed 24-bit registers read as 32 bits, sign extended to 28
// - plain registers read zero padded to 32 bits, no sign extension
// - word at 0x43B6 enables or bypasses current highpass, resets zero
// - 0x43BF reads 28-bit signed sum of three phase current samples
// - rms results read only at 0x43C0..0x43C6 in fixed phase order
// - signed no-load levels at 0x43B0..0x43B2, each resetting zero
// - signed neutral mismatch level at 0x43B8 limits current sum check
// - signed fundamental power level at 0x43B3, resetting zero
//
// Register access over AXI4-Lite is this design's own decision.
module mtr_regs #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // waveform samples and rms results from the datapath
    input wire logic [23:0] phase_a_current_sample,
    input wire logic [23:0] phase_b_current_sample,
    input wire logic [23:0] phase_c_current_sample,
    input wire logic [23:0] phase_a_current_rms,
    input wire logic [23:0] phase_a_voltage_rms,
    input wire logic [23:0] phase_b_current_rms,
    input wire logic [23:0] phase_b_voltage_rms,
    input wire logic [23:0] phase_c_current_rms,
    input wire logic [23:0] phase_c_voltage_rms,
    input wire logic [23:0] neutral_current_rms,
    // settings steering the datapath
    output logic [47:0] apparent_accum_threshold,
    output logic [47:0] active_accum_threshold,
    output logic [47:0] reactive_accum_threshold,
    output logic [23:0] apparent_noload_level,
    output logic [23:0] active_noload_level,
    output logic [23:0] reactive_noload_level,
    output logic [23:0] fundamental_power_level,
    output logic [23:0] integrator_coefficient,
    output logic [23:0] current_highpass_disable,
    output logic [23:0] neutral_mismatch_level,
    output logic integrator_coeff_loaded,
    output logic [27:0] phase_current_total
);

    // word index up to 0x43FF must fit fifteen bits beside the two byte bits
    if (ADDR_W < 17 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 17 and 32");
    end

    typedef struct packed {
        logic aw_full;
        logic [15:0] aw_idx;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [mtr_pkg::CFG_WORDS-1:0][23:0] cfg;
        logic [27:0] total;
    } mtr_state_t;

    mtr_state_t state;
    mtr_state_t next_state;
    logic wr_fire;
    logic ar_fire;
    logic [15:0] ar_idx;
    logic [3:0] cfg_slot;
    logic [27:0] sample_sum;

    // byte address to word index
    function automatic logic [15:0] word_of(input logic [ADDR_W-1:0] addr);
        word_of = 16'(addr >> 2);
    endfunction

    // 24-bit signed word sign extended to 28, four zero msbs
    function automatic logic [31:0] fmt_zpse(input logic [23:0] v);
        fmt_zpse = {4'h0, {4{v[23]}}, v};
    endfunction

    // 24-bit word with eight zero msbs
    function automatic logic [31:0] fmt_zp24(input logic [23:0] v);
        fmt_zp24 = {8'h00, v};
    endfunction

    // slot of a configuration word, valid only inside 0x43A9..0x43B8
    function automatic logic [3:0] slot_of(input logic [15:0] idx);
        slot_of = 4'(idx - mtr_pkg::IDX_APPARENT_THR_HIGH);
    endfunction

    function automatic logic in_cfg(input logic [15:0] idx);
        in_cfg = idx >= mtr_pkg::IDX_APPARENT_THR_HIGH && idx <= mtr_pkg::IDX_NEUTRAL_MISMATCH;
    endfunction

    function automatic logic in_window(input logic [15:0] idx);
        in_window = idx >= mtr_pkg::IDX_APPARENT_THR_HIGH && idx <= mtr_pkg::IDX_WINDOW_LAST;
    endfunction

    // sign extend each sample to 28 bits before adding so no carry is lost
    assign sample_sum = 28'({{4{phase_a_current_sample[23]}}, phase_a_current_sample}
        + {{4{phase_b_current_sample[23]}}, phase_b_current_sample}
        + {{4{phase_c_current_sample[23]}}, phase_c_current_sample});

    // handshakes: one write and one read in flight at a time
    assign s_axi_awready = !state.aw_full;
    assign s_axi_wready = !state.w_full;
    assign s_axi_arready = !state.rvalid;
    assign wr_fire = state.aw_full && state.w_full && !state.bvalid;
    assign ar_fire = s_axi_arvalid && !state.rvalid;
    assign ar_idx = word_of(s_axi_araddr);
    assign cfg_slot = slot_of(state.aw_idx);

    // next state: channel capture, register update, read mux
    always_comb
    begin
        next_state = state;
        if (s_axi_awvalid && !state.aw_full)
        begin
            next_state.aw_full = 1'b1;
            next_state.aw_idx = word_of(s_axi_awaddr);
        end
        if (s_axi_wvalid && !state.w_full)
        begin
            next_state.w_full = 1'b1;
            next_state.wdata = s_axi_wdata;
            next_state.wstrb = s_axi_wstrb;
        end
        if (state.bvalid && s_axi_bready)
        begin
            next_state.bvalid = 1'b0;
        end
        if (wr_fire)
        begin
            next_state.aw_full = 1'b0;
            next_state.w_full = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = in_window(state.aw_idx) ? mtr_pkg::RESP_OKAY
                : mtr_pkg::RESP_SLVERR;
            // read-only and reserved words drop the data silently
            if (in_cfg(state.aw_idx) && mtr_pkg::CFG_WRITABLE[cfg_slot])
            begin
                for (int b = 0; b < 3; b++)
                begin
                    if (state.wstrb[b])
                    begin
                        next_state.cfg[cfg_slot][8*b +: 8] = state.wdata[8*b +: 8];
                    end
                end
            end
        end
        // summed current refreshes every cycle
        next_state.total = sample_sum;
        if (state.rvalid && s_axi_rready)
        begin
            next_state.rvalid = 1'b0;
        end
        if (ar_fire)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp = in_window(ar_idx) ? mtr_pkg::RESP_OKAY : mtr_pkg::RESP_SLVERR;
            next_state.rdata = 32'h00000000;
            if (in_cfg(ar_idx) && mtr_pkg::CFG_WRITABLE[slot_of(ar_idx)])
            begin
                if (mtr_pkg::CFG_SIGNED[slot_of(ar_idx)])
                begin
                    next_state.rdata = fmt_zpse(state.cfg[slot_of(ar_idx)]);
                end
                else
                begin
                    next_state.rdata = fmt_zp24(state.cfg[slot_of(ar_idx)]);
                end
            end
            else
            begin
                case (ar_idx)
                    mtr_pkg::IDX_PHASE_CURRENT_TOTAL:
                        next_state.rdata = {4'h0, state.total};
                    mtr_pkg::IDX_PHASE_A_CURRENT_RMS:
                        next_state.rdata = fmt_zp24(phase_a_current_rms);
                    mtr_pkg::IDX_PHASE_A_VOLTAGE_RMS:
                        next_state.rdata = fmt_zp24(phase_a_voltage_rms);
                    mtr_pkg::IDX_PHASE_B_CURRENT_RMS:
                        next_state.rdata = fmt_zp24(phase_b_current_rms);
                    mtr_pkg::IDX_PHASE_B_VOLTAGE_RMS:
                        next_state.rdata = fmt_zp24(phase_b_voltage_rms);
                    mtr_pkg::IDX_PHASE_C_CURRENT_RMS:
                        next_state.rdata = fmt_zp24(phase_c_current_rms);
                    mtr_pkg::IDX_PHASE_C_VOLTAGE_RMS:
                        next_state.rdata = fmt_zp24(phase_c_voltage_rms);
                    mtr_pkg::IDX_NEUTRAL_CURRENT_RMS:
                        next_state.rdata = fmt_zp24(neutral_current_rms);
                    default:
                        next_state.rdata = 32'h00000000;
                endcase
            end
        end
    end

    // state register; every configuration word clears to zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // response channels
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;

    // settings as 48-bit thresholds and 24-bit levels for the datapath
    assign apparent_accum_threshold = {state.cfg[0], state.cfg[1]};
    assign active_accum_threshold = {state.cfg[2], state.cfg[3]};
    assign reactive_accum_threshold = {state.cfg[4], state.cfg[5]};
    assign apparent_noload_level = state.cfg[7];
    assign active_noload_level = state.cfg[8];
    assign reactive_noload_level = state.cfg[9];
    assign fundamental_power_level = state.cfg[10];
    assign integrator_coefficient = state.cfg[12];
    assign current_highpass_disable = state.cfg[13];
    assign neutral_mismatch_level = state.cfg[15];
    // lets the integrator tell whether the host loaded the needed coefficient
    assign integrator_coeff_loaded = state.cfg[12] == mtr_pkg::INTEGRATOR_COEFF_ON;
    assign phase_current_total = state.total;

    // checks
    sequence s_full_write(logic [15:0] idx);
        wr_fire && state.aw_idx == idx && state.wstrb == 4'hF;
    endsequence

    sequence s_read(logic [15:0] idx);
        ar_fire && ar_idx == idx;
    endsequence

    property p_apparent_thr;
        @(posedge clk) disable iff (!rstn)
        s_full_write(mtr_pkg::IDX_APPARENT_THR_LOW)
        |=> apparent_accum_threshold[23:0] == $past(state.wdata[23:0]);
    endproperty
    a_apparent_thr: assert property (p_apparent_thr)
        else $error("apparent low half not stored");

    property p_active_thr;
        @(posedge clk) disable iff (!rstn)
        s_full_write(mtr_pkg::IDX_ACTIVE_THR_HIGH)
        |=> active_accum_threshold[47:24] == $past(state.wdata[23:0])
            && s_axi_bvalid && s_axi_bresp == mtr_pkg::RESP_OKAY;
    endproperty
    a_active_thr: assert property (p_active_thr)
        else $error("active high half not stored");

    property p_reactive_thr;
        @(posedge clk) disable iff (!rstn)
        s_full_write(mtr_pkg::IDX_REACTIVE_THR_LOW)
        |=> reactive_accum_threshold[23:0] == $past(state.wdata[23:0])
            && $stable(reactive_accum_threshold[47:24]);
    endproperty
    a_reactive_thr: assert property (p_reactive_thr)
        else $error("reactive low half wrong");

    property p_signed_read;
        @(posedge clk) disable iff (!rstn)
        s_read(mtr_pkg::IDX_ACTIVE_NOLOAD)
        |=> s_axi_rdata[31:28] == 4'h0 && s_axi_rdata[27:24] == {4{s_axi_rdata[23]}}
            && s_axi_rdata[23:0] == $past(active_noload_level);
    endproperty
    a_signed_read: assert property (p_signed_read)
        else $error("signed read not extended");

    property p_plain_read;
        @(posedge clk) disable iff (!rstn)
        s_read(mtr_pkg::IDX_HIGHPASS_DISABLE)
        |=> s_axi_rvalid && s_axi_rdata == {8'h00, $past(current_highpass_disable)};
    endproperty
    a_plain_read: assert property (p_plain_read)
        else $error("plain read not zero padded");

    property p_highpass_reset;
        @(posedge clk)
        !rstn |=> current_highpass_disable == 24'h000000;
    endproperty
    a_highpass_reset: assert property (p_highpass_reset)
        else $error("highpass word not zero");

    property p_total;
        @(posedge clk) disable iff (!rstn)
        s_read(mtr_pkg::IDX_PHASE_CURRENT_TOTAL)
        |=> s_axi_rdata == {4'h0, $past(phase_current_total)}
            ##1 phase_current_total == $past(sample_sum);
    endproperty
    a_total: assert property (p_total) else $error("current total read wrong");

    property p_rms_order;
        @(posedge clk) disable iff (!rstn)
        s_read(mtr_pkg::IDX_PHASE_B_VOLTAGE_RMS)
        |=> s_axi_rdata == {8'h00, $past(phase_b_voltage_rms)}
            && s_axi_rresp == mtr_pkg::RESP_OKAY;
    endproperty
    a_rms_order: assert property (p_rms_order) else $error("rms read out of order");

    property p_noload;
        @(posedge clk) disable iff (!rstn)
        s_full_write(mtr_pkg::IDX_REACTIVE_NOLOAD)
        |=> reactive_noload_level == $past(state.wdata[23:0]);
    endproperty
    a_noload: assert property (p_noload) else $error("no-load level not stored");

    property p_mismatch;
        @(posedge clk) disable iff (!rstn)
        s_full_write(mtr_pkg::IDX_NEUTRAL_MISMATCH)
        |=> neutral_mismatch_level == $past(state.wdata[23:0]) && $stable(fundamental_power_level);
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatch level not stored");

    property p_level;
        @(posedge clk) disable iff (!rstn)
        s_full_write(mtr_pkg::IDX_FUNDAMENTAL_LEVEL)
        |=> fundamental_power_level == $past(state.wdata[23:0]);
    endproperty
    a_level: assert property (p_level) else $error("fundamental level not stored");

    property p_readonly;
        @(posedge clk) disable iff (!rstn)
        wr_fire && state.aw_idx >= mtr_pkg::IDX_PHASE_CURRENT_TOTAL
            && state.aw_idx <= mtr_pkg::IDX_NEUTRAL_CURRENT_RMS
        |=> $stable(state.cfg);
    endproperty
    a_readonly: assert property (p_readonly)
        else $error("read-only write had effect");

endmodule

// *** tb/mtr_host.sv ***
// host model: axi4-lite master on the register port
module mtr_host #(
    parameter int ADDR_W = 18
) (
    // clock
    input wire logic clk,
    // write channels
    output logic [ADDR_W-1:0] awaddr,
    output logic [2:0] awprot,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read channels
    output logic [ADDR_W-1:0] araddr,
    output logic [2:0] arprot,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial
    begin
        awaddr = '0;
        araddr = '0;
        awprot = 3'h0;
        arprot = 3'h0;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // one write; released lines get inverted so stale values never look valid
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        r = 2'h3;
        if (idx == 16'h43B4 || (idx >= 16'h43C7 && idx <= 16'h43FF)) // never written
        begin
            return;
        end
        if (idx == 16'h43AF || idx == 16'h43B7
            || (idx >= 16'h43B9 && idx <= 16'h43BE))
        begin
            d = 32'h00000000;
        end
        @(posedge clk);
        awaddr <= ADDR_W'({idx, 2'b00});
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (awvalid && awready)
            begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready)
            begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (bvalid && bready)
            begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // one read; rready held until the answer is sampled
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= ADDR_W'({idx, 2'b00});
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (arvalid && arready)
            begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (rvalid && rready)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule

// *** tb/tb_mtr_regs.sv ***
// self-checking bench for the threshold and rms register bank
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("unexpected %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_mtr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [17:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [23:0] samp_a = 24'h000000, samp_b = 24'h000000, samp_c = 24'h000000;
    logic [23:0] rms [0:6];
    logic [47:0] ap_thr, ac_thr, re_thr;
    logic [23:0] ap_nl, ac_nl, re_nl, fund_lvl, int_coef, hp_dis, nm_lvl;
    logic coef_ok;
    logic [27:0] total;
    int err_total = 0;
    int compares = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    mtr_regs u_mtr_regs (
        .clk(clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready),
        .phase_a_current_sample(samp_a), .phase_b_current_sample(samp_b),
        .phase_c_current_sample(samp_c),
        .phase_a_current_rms(rms[0]), .phase_a_voltage_rms(rms[1]),
        .phase_b_current_rms(rms[2]), .phase_b_voltage_rms(rms[3]),
        .phase_c_current_rms(rms[4]), .phase_c_voltage_rms(rms[5]),
        .neutral_current_rms(rms[6]),
        .apparent_accum_threshold(ap_thr), .active_accum_threshold(ac_thr),
        .reactive_accum_threshold(re_thr), .apparent_noload_level(ap_nl),
        .active_noload_level(ac_nl), .reactive_noload_level(re_nl),
        .fundamental_power_level(fund_lvl), .integrator_coefficient(int_coef),
        .current_highpass_disable(hp_dis), .neutral_mismatch_level(nm_lvl),
        .integrator_coeff_loaded(coef_ok), .phase_current_total(total)
    );

    mtr_host u_mtr_host (
        .clk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready
    );

    // bit 23 set in every pattern so sign handling shows
    function automatic logic [23:0] pat(input int i);
        return {4'hC, i[3:0], 16'h5A3C};
    endfunction

    // word as it travels on the bus for config index i
    function automatic logic [31:0] fmt(input int i, input logic [23:0] v);
        if (!mtr_pkg::CFG_WRITABLE[i])
        begin
            return 32'h00000000;
        end
        if (mtr_pkg::CFG_SIGNED[i])
        begin
            return {4'h0, {4{v[23]}}, v};
        end
        return {8'h00, v};
    endfunction

    task automatic wchk(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        u_mtr_host.wr(idx, d, r);
        `CHK("bresp", er, r)
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_mtr_host.rd(idx, d, r);
        `CHK("rresp", er, r)
        `CHK("rdata", e, d)
    endtask

    // drive three samples, then see the sum at the port and on the bus
    task automatic sumchk(input logic [23:0] a, b, c, input logic [27:0] e);
        @(posedge clk);
        samp_a <= a;
        samp_b <= b;
        samp_c <= c;
        repeat (2) @(posedge clk);
        `CHK("total", e, total)
        rchk(mtr_pkg::IDX_PHASE_CURRENT_TOTAL, {4'h0, e}, mtr_pkg::RESP_OKAY);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence
    initial
    begin
        for (int k = 0; k < 7; k++)
        begin
            rms[k] = {4'h8, 4'(k), 16'hBEEF};
        end
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            rchk(16'h43A9 + 16'(i), 32'h00000000, 2'h0); // zero
        end
        // 0x43B4 is skipped: the host never writes it
        for (int i = 0; i < 16; i++)
        begin
            if (i != 11)
            begin
                wchk(16'h43A9 + 16'(i), fmt(i, pat(i)), 2'h0); // fill
            end
        end
        for (int i = 0; i < 16; i++)
        begin
            rchk(16'h43A9 + 16'(i), fmt(i, pat(i)), 2'h0); // formats
        end
        `CHK("apparent thr", {pat(0), pat(1)}, ap_thr); // halves
        `CHK("active thr", {pat(2), pat(3)}, ac_thr); // halves
        `CHK("reactive thr", {pat(4), pat(5)}, re_thr); // halves
        `CHK("noload", {pat(7), pat(8), pat(9)}, {ap_nl, ac_nl, re_nl}); // order
        `CHK("fund level", pat(10), fund_lvl); // level word
        `CHK("hpf word", pat(13), hp_dis); // filter select
        `CHK("mismatch", pat(15), nm_lvl); // neutral limit
        `CHK("coef flag", 1'b0, coef_ok); // not yet loaded
        wchk(mtr_pkg::IDX_INTEGRATOR_COEFF, 32'h0FFF8000, 2'h0); // integrator on
        rchk(mtr_pkg::IDX_INTEGRATOR_COEFF, 32'h0FFF8000, 2'h0); // sign extended
        `CHK("coef", 24'hFF8000, int_coef); // loaded value
        `CHK("coef flag", 1'b1, coef_ok); // loaded
        sumchk(24'h800000, 24'h800001, 24'hFFFFFF, 28'hF000000); // negative
        sumchk(24'h7FFFFF, 24'h7FFFFF, 24'h7FFFFF, 28'h17FFFFD); // positive
        for (int k = 0; k < 7; k++)
        begin
            rchk(16'h43C0 + 16'(k), {8'h00, rms[k]}, 2'h0); // rms order
        end
        wchk(mtr_pkg::IDX_PHASE_CURRENT_TOTAL, 32'h0ABCDEF0, 2'h0); // ignored
        wchk(mtr_pkg::IDX_PHASE_B_VOLTAGE_RMS, 32'h00123456, 2'h0); // ignored
        rchk(mtr_pkg::IDX_PHASE_CURRENT_TOTAL, 32'h017FFFFD, 2'h0); // intact
        rchk(mtr_pkg::IDX_PHASE_B_VOLTAGE_RMS, {8'h00, rms[3]}, 2'h0); // intact
        // unmapped index just below the bank
        wchk(16'h43A8, 32'h00FFFFFF, mtr_pkg::RESP_SLVERR); // dropped
        rchk(16'h43A8, 32'h00000000, mtr_pkg::RESP_SLVERR); // reads zero
        `CHK("apparent thr", {pat(0), pat(1)}, ap_thr); // untouched
        // a wrapped slot number would land these writes on live words
        `CHK("mapped words", {pat(10), pat(15)}, {fund_lvl, nm_lvl}); // no alias
        // second reset in mid-run clears the settings
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK("hpf word", 24'h000000, hp_dis); // reset zero
        `CHK("apparent thr", 48'h000000000000, ap_thr); // reset zero
        `CHK("coef flag", 1'b0, coef_ok); // cleared
        rchk(mtr_pkg::IDX_HIGHPASS_DISABLE, 32'h00000000, 2'h0); // bus after reset
        tally_and_finish();
    end

    // watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule
